// file: rmc_cmd_handler.sv
`timescale 1ns/1ps
`include "rmc_params.svh"
module rmc_cmd_handler #(
  parameter logic [39:0] RETRY_CYC = 40'(`RMC_RETRY_CYC),
  parameter logic [39:0] WINDOW_CYC = 40'(`RMC_WINDOW_CYC),
  parameter logic [39:0] HOLD_CYC = 40'(`RMC_HOLD_CYC),
  parameter logic [39:0] HOUR_CYC = 40'(`RMC_HOUR_CYC),
  parameter logic FAN_READ_SUPPORTED = 1'b1
) (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic reset_n_i,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [5:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Unit pins and monitors (asynchronous)
  input wire logic enable_pin_i,
  input wire logic ac_ok_i,
  input wire logic present_i,
  input wire logic ov_trip_i,
  input wire logic operating_i,
  input wire logic iso_done_i,
  input wire logic iso_fail_i,
  // Measurements and internal demand (same clock)
  input wire logic [8:0] vin_volts_i,
  input wire logic [15:0] pin_watts_i,
  input wire logic [7:0] fan_internal_i,
  input wire logic [2:0] fan_fitted_i,
  input wire logic [23:0] fan_speed_i,
  input wire logic [23:0] revisions_i,
  // Outputs
  output logic output_on_o,
  output logic latched_off_o,
  output logic alarm_clear_o,
  output logic iso_start_o,
  output logic [7:0] fan_duty_o,
  output logic scl_hold_o,
  output logic alert_n_o
);

  // ----------------------------------------
  // Functions
  // ----------------------------------------
  function automatic logic [7:0] crc8_step(input logic [7:0] crc,
                                           input logic [7:0] data);
    logic [7:0] x;
    x = crc ^ data;
    for (int i = 0; i < 8; i++) begin
      x = x[7] ? ((x << 1) ^ `RMC_CRC_POLY) : (x << 1);
    end
    return x;
  endfunction

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  localparam int NSYNC = 7;
  logic [NSYNC-1:0] sync1_reg;
  logic [NSYNC-1:0] sync2_reg;
  logic [NSYNC-1:0] pins_q_reg;
  logic [NSYNC-1:0] pins_raw;
  assign pins_raw = {iso_fail_i, iso_done_i, operating_i, ov_trip_i,
                     present_i, ac_ok_i, enable_pin_i};
  genvar g;
  generate
    for (g = 0; g < NSYNC; g++) begin : g_sync
      always_ff @(posedge ref_clk_i) begin
        if (!reset_n_i) begin
          sync1_reg[g] <= 1'b0;
          sync2_reg[g] <= 1'b0;
          pins_q_reg[g] <= 1'b0;
        end else begin
          sync1_reg[g] <= pins_raw[g];
          sync2_reg[g] <= sync1_reg[g];
          pins_q_reg[g] <= sync2_reg[g];
        end
      end
    end
  endgenerate
  logic en_off;
  logic ac_ok;
  logic present;
  logic ov_rise;
  logic operating;
  logic iso_done_rise;
  logic iso_fail;
  assign en_off = sync2_reg[0];
  assign ac_ok = sync2_reg[1];
  assign present = sync2_reg[2];
  assign ov_rise = sync2_reg[3] & ~pins_q_reg[3];
  assign operating = sync2_reg[4];
  assign iso_done_rise = sync2_reg[5] & ~pins_q_reg[5];
  assign iso_fail = sync2_reg[6];

  // ----------------------------------------
  // Wishbone slave
  // ----------------------------------------
  logic bus_req;
  logic wr_take;
  logic cmd_write;
  logic st2_write;
  assign bus_req = wb_cyc_i & wb_stb_i;
  // Writes land on the edge where the master samples ack
  assign wr_take = bus_req & wb_ack_o & wb_we_i;
  assign cmd_write = wr_take & (wb_adr_i == `RMC_OFS_CMD) & wb_sel_i[0];
  assign st2_write = wr_take & (wb_adr_i == `RMC_OFS_STATUS2);

  rmc_pkg::rmc_state_t state_reg;
  logic [7:0] resp_reg [0:5];
  logic [2:0] resp_len_reg;
  logic [7:0] cmd_reg;
  logic [7:0] st2_reg;
  logic [23:0] hours_reg;
  logic [7:0] fan_req_reg;
  logic fan_override_reg;
  logic latched_reg;
  logic auto_policy_reg;
  logic op_on_reg;
  logic retry_wait_reg;
  logic iso_pass_reg;
  logic [3:0] off_seen_reg;
  logic accept;
  logic crc_bad;
  assign accept = cmd_write & (state_reg == rmc_pkg::RMC_IDLE);
  assign crc_bad = wb_dat_i[16];

  always_ff @(posedge ref_clk_i) begin
    if (!reset_n_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0;
    end else begin
      wb_ack_o <= bus_req & ~wb_ack_o;
      wb_dat_o <= 32'h0;
      if (bus_req & ~wb_ack_o & ~wb_we_i) begin
        case (wb_adr_i)
          `RMC_OFS_CMD: wb_dat_o <= {23'h0,
                                     state_reg == rmc_pkg::RMC_CRC, cmd_reg};
          `RMC_OFS_STATUS2: wb_dat_o <= {24'h0, st2_reg};
          `RMC_OFS_RESP_LO: wb_dat_o <= {resp_reg[3], resp_reg[2],
                                         resp_reg[1], resp_reg[0]};
          `RMC_OFS_RESP_HI: wb_dat_o <= {5'h00, resp_len_reg, 8'h00,
                                         resp_reg[5], resp_reg[4]};
          `RMC_OFS_HOURS: wb_dat_o <= {8'h00, hours_reg};
          `RMC_OFS_FAN: wb_dat_o <= {15'h0, fan_override_reg,
                                     fan_req_reg, fan_duty_o};
          `RMC_OFS_STATE: wb_dat_o <= {26'h0, iso_pass_reg,
                                       retry_wait_reg, auto_policy_reg,
                                       op_on_reg, latched_reg, output_on_o};
          default: wb_dat_o <= 32'h0;
        endcase
      end
    end
  end

  // ----------------------------------------
  // Command decode and response builder
  // ----------------------------------------
  logic [8:0] vin_adj;
  logic [7:0] vin_byte;
  logic [2:0] crc_idx_reg;
  logic [7:0] crc_reg;
  logic [7:0] crc_byte;
  // (RULE11) Offset input voltage
  assign vin_adj = (vin_volts_i > `RMC_VIN_OFFSET) ?
                   (vin_volts_i - `RMC_VIN_OFFSET) : 9'h000;
  assign vin_byte = vin_adj[8] ? 8'hFF : vin_adj[7:0];

  always_comb begin
    case (crc_idx_reg)
      3'h0: crc_byte = {`RMC_SLAVE_ADDR, 1'b0};
      3'h1: crc_byte = cmd_reg;
      3'h2: crc_byte = {`RMC_SLAVE_ADDR, 1'b1};
      3'h3: crc_byte = resp_reg[0];
      3'h4: crc_byte = resp_reg[1];
      3'h5: crc_byte = resp_reg[2];
      3'h6: crc_byte = resp_reg[3];
      default: crc_byte = resp_reg[4];
    endcase
  end

  always_ff @(posedge ref_clk_i) begin
    if (!reset_n_i) begin
      state_reg <= rmc_pkg::RMC_IDLE;
      cmd_reg <= 8'h00;
      resp_len_reg <= 3'h0;
      crc_idx_reg <= 3'h0;
      crc_reg <= 8'h00;
      for (int i = 0; i < 6; i++) begin
        resp_reg[i] <= 8'h00;
      end
    end else begin
      case (state_reg)
        rmc_pkg::RMC_IDLE: begin
          // (RULE25) Bad error code drops command
          if (accept && !crc_bad) begin
            cmd_reg <= wb_dat_i[7:0];
            crc_idx_reg <= 3'h0;
            crc_reg <= 8'h00;
            for (int i = 0; i < 6; i++) begin
              resp_reg[i] <= 8'h00;
            end
            case (wb_dat_i[7:0])
              // (RULE10) Input string layout
              `RMC_CMD_READ_INPUT: begin
                resp_reg[0] <= `RMC_CNT_INPUT;
                resp_reg[1] <= vin_byte;
                resp_reg[2] <= pin_watts_i[7:0];
                resp_reg[3] <= pin_watts_i[15:8];
                resp_len_reg <= 3'h5;
                state_reg <= rmc_pkg::RMC_CRC;
              end
              // (RULE12) Revision order
              // (RULE13) Zero passes through as unsupported
              `RMC_CMD_READ_REV: begin
                resp_reg[0] <= `RMC_CNT_REV;
                resp_reg[1] <= revisions_i[7:0];
                resp_reg[2] <= revisions_i[15:8];
                resp_reg[3] <= revisions_i[23:16];
                resp_len_reg <= 3'h5;
                state_reg <= rmc_pkg::RMC_CRC;
              end
              // (RULE14) Hours low byte first
              `RMC_CMD_READ_TIMER: begin
                resp_reg[0] <= `RMC_CNT_TIMER;
                resp_reg[1] <= hours_reg[7:0];
                resp_reg[2] <= hours_reg[15:8];
                resp_reg[3] <= hours_reg[23:16];
                resp_len_reg <= 3'h5;
                state_reg <= rmc_pkg::RMC_CRC;
              end
              // (RULE19) Fan readback layout
              `RMC_CMD_READ_FAN: begin
                resp_reg[0] <= `RMC_CNT_FAN;
                resp_len_reg <= 3'h6;
                state_reg <= rmc_pkg::RMC_CRC;
                // (RULE20) Zero for absent fans
                if (FAN_READ_SUPPORTED) begin
                  resp_reg[1] <= fan_override_reg ? fan_req_reg : 8'h00;
                  for (int i = 0; i < 3; i++) begin
                    resp_reg[2+i] <= fan_fitted_i[i] ?
                                     fan_speed_i[8*i +: 8] : 8'h00;
                  end
                end
              end
              default: resp_len_reg <= 3'h0;
            endcase
          end
        end
        rmc_pkg::RMC_CRC: begin
          // Error code covers both addresses, the command and the bytes
          crc_reg <= crc8_step(crc_reg, crc_byte);
          crc_idx_reg <= crc_idx_reg + 3'h1;
          if (crc_idx_reg == resp_len_reg + 3'h1) begin
            resp_reg[resp_len_reg - 3'h1] <= crc8_step(crc_reg, crc_byte);
            state_reg <= rmc_pkg::RMC_IDLE;
          end
        end
        default: state_reg <= rmc_pkg::RMC_IDLE;
      endcase
    end
  end

  // ----------------------------------------
  // Command side effects
  // ----------------------------------------
  logic exec;
  logic [7:0] cmd_in;
  logic [7:0] data_in;
  logic is_read;
  logic bad_data;
  logic unsupported;
  assign exec = accept & ~crc_bad;
  assign cmd_in = wb_dat_i[7:0];
  assign data_in = wb_dat_i[15:8];
  assign is_read = (cmd_in == `RMC_CMD_READ_INPUT) |
                   (cmd_in == `RMC_CMD_READ_REV) |
                   (cmd_in == `RMC_CMD_READ_TIMER) |
                   (cmd_in == `RMC_CMD_READ_FAN);
  assign bad_data = ((cmd_in == `RMC_CMD_FAN_SET) &
                     (data_in > `RMC_FAN_FULL)) |
                    ((cmd_in == `RMC_CMD_OPERATION) &
                     (data_in != `RMC_OP_ON) & (data_in != `RMC_OP_OFF));
  assign unsupported = ~is_read & (cmd_in != `RMC_CMD_OPERATION) &
                       (cmd_in != `RMC_CMD_AUTO_RESTART) &
                       (cmd_in != `RMC_CMD_ISO_TEST) &
                       (cmd_in != `RMC_CMD_FAN_SET) &
                       (cmd_in != `RMC_CMD_FAN_NORMAL) &
                       (cmd_in != `RMC_CMD_CLOCK_HOLD);

  always_ff @(posedge ref_clk_i) begin
    if (!reset_n_i) begin
      fan_req_reg <= 8'h00;
      fan_override_reg <= 1'b0;
    end else if (exec && !bad_data) begin
      // (RULE16) One duty byte in percent
      if (cmd_in == `RMC_CMD_FAN_SET) begin
        fan_req_reg <= data_in;
        fan_override_reg <= 1'b1;
      end
      // (RULE18) Back to internal control
      if (cmd_in == `RMC_CMD_FAN_NORMAL) begin
        fan_override_reg <= 1'b0;
      end
    end
  end

  // (RULE17) Never below internal demand
  always_ff @(posedge ref_clk_i) begin
    if (!reset_n_i) begin
      fan_duty_o <= 8'h00;
    end else if (fan_override_reg && fan_req_reg > fan_internal_i) begin
      fan_duty_o <= fan_req_reg;
    end else begin
      fan_duty_o <= fan_internal_i;
    end
  end

  // (RULE21) Hold serial clock low
  logic [39:0] hold_cnt_reg;
  always_ff @(posedge ref_clk_i) begin
    if (!reset_n_i) begin
      scl_hold_o <= 1'b0;
      hold_cnt_reg <= 40'h0;
    end else if (exec && cmd_in == `RMC_CMD_CLOCK_HOLD) begin
      scl_hold_o <= 1'b1;
      hold_cnt_reg <= 40'h0;
    end else if (scl_hold_o) begin
      hold_cnt_reg <= hold_cnt_reg + 40'h1;
      if (hold_cnt_reg == HOLD_CYC - 40'h1) begin
        scl_hold_o <= 1'b0;
      end
    end
  end

  // (RULE7) Start the OR-ing self-test
  always_ff @(posedge ref_clk_i) begin
    if (!reset_n_i) begin
      iso_start_o <= 1'b0;
      iso_pass_reg <= 1'b0;
    end else begin
      iso_start_o <= exec & (cmd_in == `RMC_CMD_ISO_TEST);
      if (iso_done_rise) begin
        iso_pass_reg <= ~iso_fail;
      end
    end
  end

  // (RULE15) Run hours in standby or output
  logic [39:0] hour_pre_reg;
  always_ff @(posedge ref_clk_i) begin
    if (!reset_n_i) begin
      hour_pre_reg <= 40'h0;
      hours_reg <= 24'h0;
    end else if (wr_take && wb_adr_i == `RMC_OFS_HOURS) begin
      // Preload keeps the count across bias loss
      hours_reg <= wb_dat_i[23:0];
      hour_pre_reg <= 40'h0;
    end else if (operating) begin
      if (hour_pre_reg == HOUR_CYC - 40'h1) begin
        hour_pre_reg <= 40'h0;
        if (hours_reg != 24'hFFFFFF) begin
          hours_reg <= hours_reg + 24'h1;
        end
      end else begin
        hour_pre_reg <= hour_pre_reg + 40'h1;
      end
    end
  end

  // ----------------------------------------
  // Latch-off, restart and overvoltage retry
  // ----------------------------------------
  logic [1:0] ov_cnt_reg;
  logic win_run_reg;
  logic [39:0] win_cnt_reg;
  logic [39:0] retry_cnt_reg;
  logic op_off_cmd;
  logic op_on_cmd;
  logic restart_cmd;
  logic [3:0] off_now;
  logic restart_go;
  assign op_off_cmd = exec & (cmd_in == `RMC_CMD_OPERATION) &
                      (data_in == `RMC_OP_OFF);
  assign op_on_cmd = exec & (cmd_in == `RMC_CMD_OPERATION) &
                     (data_in == `RMC_OP_ON);
  assign restart_cmd = exec & (cmd_in == `RMC_CMD_AUTO_RESTART);
  assign off_now = {~ac_ok, ~present, ~op_on_reg, en_off};
  // (RULE3) Off then on of any source, or restart command
  assign restart_go = latched_reg &
                      (restart_cmd | (|(off_seen_reg & ~off_now)));

  always_ff @(posedge ref_clk_i) begin
    if (!reset_n_i) begin
      op_on_reg <= 1'b1;
    end else if (op_off_cmd) begin
      op_on_reg <= 1'b0;
    end else if (op_on_cmd) begin
      op_on_reg <= 1'b1;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!reset_n_i) begin
      auto_policy_reg <= 1'b1;
    end else if (restart_cmd) begin
      // (RULE4) Back to automatic restart
      auto_policy_reg <= 1'b1;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!reset_n_i) begin
      latched_reg <= 1'b0;
      off_seen_reg <= 4'h0;
      ov_cnt_reg <= 2'h0;
      win_run_reg <= 1'b0;
      win_cnt_reg <= 40'h0;
      retry_wait_reg <= 1'b0;
      retry_cnt_reg <= 40'h0;
    end else begin
      if (latched_reg) begin
        off_seen_reg <= off_seen_reg | off_now;
      end
      if (restart_go) begin
        latched_reg <= 1'b0;
        off_seen_reg <= 4'h0;
      end
      // (RULE6) Window ran out below the limit
      if (win_run_reg) begin
        win_cnt_reg <= win_cnt_reg + 40'h1;
        if (win_cnt_reg == WINDOW_CYC - 40'h1) begin
          win_run_reg <= 1'b0;
          ov_cnt_reg <= 2'h0;
        end
      end
      // (RULE5) One second delay per retry
      if (retry_wait_reg) begin
        retry_cnt_reg <= retry_cnt_reg + 40'h1;
        if (retry_cnt_reg == RETRY_CYC - 40'h1) begin
          retry_wait_reg <= 1'b0;
        end
      end
      // (RULE5) Third shutdown in window latches
      if (ov_rise && !latched_reg) begin
        if (ov_cnt_reg == `RMC_OV_LIMIT - 2'h1 || !auto_policy_reg) begin
          latched_reg <= 1'b1;
          off_seen_reg <= 4'h0;
          ov_cnt_reg <= 2'h0;
          win_run_reg <= 1'b0;
          retry_wait_reg <= 1'b0;
        end else begin
          ov_cnt_reg <= ov_cnt_reg + 2'h1;
          retry_wait_reg <= 1'b1;
          retry_cnt_reg <= 40'h0;
          if (!win_run_reg) begin
            win_run_reg <= 1'b1;
            win_cnt_reg <= 40'h0;
          end
        end
      end
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!reset_n_i) begin
      output_on_o <= 1'b0;
      latched_off_o <= 1'b0;
      alarm_clear_o <= 1'b0;
    end else begin
      output_on_o <= ~latched_reg & ~retry_wait_reg & op_on_reg &
                     ~en_off & ac_ok & present;
      latched_off_o <= latched_reg;
      // (RULE2) Restart clears the alarm registers
      alarm_clear_o <= restart_go;
    end
  end

  // ----------------------------------------
  // Status-2 and alert
  // ----------------------------------------
  always_ff @(posedge ref_clk_i) begin
    if (!reset_n_i) begin
      st2_reg <= 8'h00;
    end else begin
      st2_reg[`RMC_ST2_ENABLE_HI] <= en_off;
      st2_reg[`RMC_ST2_WILL_RESTART] <= retry_wait_reg;
      st2_reg[4] <= 1'b0;
      st2_reg[1] <= 1'b0;
      // Software clear first so that a same-cycle event still lands
      if (st2_write) begin
        st2_reg[`RMC_ST2_CRC_ERR] <= 1'b0;
        st2_reg[`RMC_ST2_INVALID] <= 1'b0;
        st2_reg[`RMC_ST2_RESTARTED] <= 1'b0;
        st2_reg[`RMC_ST2_ISO_FAIL] <= 1'b0;
      end
      // (RULE25) Error code mismatch flag
      if (accept && crc_bad) begin
        st2_reg[`RMC_ST2_CRC_ERR] <= 1'b1;
      end
      // (RULE22) Bad command or data flagged
      // (RULE23) Invalid instruction bit
      if (exec && (unsupported || bad_data)) begin
        st2_reg[`RMC_ST2_INVALID] <= 1'b1;
      end
      // (RULE24) Restarted-ok bit
      if (restart_go) begin
        st2_reg[`RMC_ST2_RESTARTED] <= 1'b1;
      end
      // (RULE9) Failure is information only
      if (iso_done_rise) begin
        st2_reg[`RMC_ST2_ISO_FAIL] <= iso_fail;
      end
    end
  end

  // (RULE22) Alert while the CRC error, invalid or restarted flag stands
  always_ff @(posedge ref_clk_i) begin
    if (!reset_n_i) begin
      alert_n_o <= 1'b1;
    end else begin
      alert_n_o <= ~(st2_reg[`RMC_ST2_CRC_ERR] | st2_reg[`RMC_ST2_INVALID] |
                     st2_reg[`RMC_ST2_RESTARTED]);
    end
  end

endmodule

// file: rmc_cmd_handler_checker.sv
`timescale 1ns/1ps
module rmc_cmd_handler_checker (
  input wire logic ref_clk_i, reset_n_i, wb_cyc_i, wb_stb_i, wb_we_i,
  input wire logic [5:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic wb_ack_o, alert_n_o, iso_start_o, scl_hold_o,
  input wire logic latched_off_o, output_on_o, alarm_clear_o,
  input wire logic [7:0] fan_internal_i, fan_duty_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!reset_n_i);
  wire wr_done = wb_cyc_i && wb_stb_i && wb_ack_o && wb_we_i;
  wire wr0 = wr_done && wb_sel_i[0] && wb_adr_i == 6'h00;
  wire cmd_wr = wr0 && !wb_dat_i[16];
  a_ack_latency: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o
    |=> wb_ack_o) else $error("ack late");
  a_iso_start: assert property (
    cmd_wr && wb_dat_i[7:0] == 8'hDA |-> ##[1:3] iso_start_o)
    else $error("isolation test not started");
  a_hold_start: assert property (
    cmd_wr && wb_dat_i[7:0] == 8'hE2 |-> ##[1:3] scl_hold_o)
    else $error("clock hold not started");
  a_hold_length: assert property ($rose(scl_hold_o)
    |-> scl_hold_o[*8]) else $error("clock hold too short");
  a_crc_alert: assert property (wr0 && wb_dat_i[16]
    |-> ##[1:3] !alert_n_o) else $error("bad code no alert");
  a_fan_limit: assert property (
    cmd_wr && wb_dat_i[7:0] == 8'hDF && wb_dat_i[15:8] > 8'h64
    |-> ##[1:3] !alert_n_o) else $error("bad duty no alert");
  a_clear_alert: assert property (
    wr_done && wb_adr_i == 6'h04 |-> ##[1:3] alert_n_o)
    else $error("alert not cleared");
  a_fan_floor: assert property (
    $past(reset_n_i, 2) && $stable(fan_internal_i)
    |-> fan_duty_o >= fan_internal_i) else $error("fan below demand");
  a_latch_dark: assert property (
    latched_off_o && $past(latched_off_o) |-> !output_on_o)
    else $error("output on while latched");
  a_restart_clear: assert property ($fell(latched_off_o)
    |-> $past(alarm_clear_o)) else $error("restart left alarms");
endmodule
bind rmc_cmd_handler rmc_cmd_handler_checker chk (.*);

// file: rmc_cmd_handler_tb.sv
`timescale 1ns/1ps
module rmc_cmd_handler_tb;
  logic ref_clk_i = 1'b0, reset_n_i = 1'b0, enable_pin_i = 1'b0;
  logic ac_ok_i = 1'b1, present_i = 1'b1, ov_trip_i = 1'b0;
  logic operating_i = 1'b0, iso_done_i = 1'b0, iso_fail_i = 1'b1;
  logic [8:0] vin_volts_i = 9'h0E6;
  logic [15:0] pin_watts_i = 16'h0412;
  logic [7:0] fan_internal_i = 8'h20;
  logic [2:0] fan_fitted_i = 3'h5;
  logic [23:0] fan_speed_i = 24'h334455, revisions_i = 24'h142100;
  wire wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, tmo;
  wire output_on_o, latched_off_o, alarm_clear_o, iso_start_o;
  wire scl_hold_o, alert_n_o;
  wire [5:0] wb_adr_i;
  wire [3:0] wb_sel_i;
  wire [31:0] wb_dat_i, wb_dat_o;
  wire [7:0] fan_duty_o;
  int n_errors = 0, checked = 0;
  logic [31:0] q;
  logic [7:0] p;
  logic f;
  logic [47:0] r;
  // Code, expected low response word, fifth data byte
  logic [47:0] rows [4] = '{{8'hDC, 32'h04129B04, 8'h00},
    {8'hDD, 32'h14210003, 8'h00}, {8'hDE, 32'h0A0B0C04, 8'h00},
    {8'hE1, 32'h00550005, 8'h33}};
  always #10 ref_clk_i = ~ref_clk_i;
  rmc_cmd_handler #(.RETRY_CYC(40'd20), .WINDOW_CYC(40'd200),
    .HOLD_CYC(40'd10), .HOUR_CYC(40'd16)) uut (.*);
  rmc_host_model host (.clk_i(ref_clk_i), .ack_i(wb_ack_o),
    .rdat_i(wb_dat_o), .cyc_o(wb_cyc_i), .stb_o(wb_stb_i), .we_o(wb_we_i),
    .tmo_o(tmo), .adr_o(wb_adr_i), .sel_o(wb_sel_i), .wdat_o(wb_dat_i));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic give_verdict();
    $display("errors %0d checks %0d", n_errors, checked);
    if (n_errors == 0 && checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // Busy is polled so the next command is never dropped
  task automatic cmd(input logic [16:0] c);
    int n;
    host.xfer(1'b1, 6'h00, {15'h0, c}, q);
    for (n = 0; n < 50; n++) begin
      host.xfer(1'b0, 6'h00, 32'h0, q);
      if (q[8] === 1'b0) break;
    end
    if (n >= 50) chk(n, 0);
  endtask
  function automatic logic [7:0] crc8(input logic [7:0] c,
      input logic [63:0] d, input int nb);
    logic [7:0] s;
    s = 8'h00;
    for (int i = 0; i < nb + 3; i++) begin
      s = s ^ ((i == 0) ? 8'hB0 : (i == 1) ? c : (i == 2) ? 8'hB1
        : d[8*(i-3)+:8]);
      repeat (8) s = s[7] ? {s[6:0], 1'b0} ^ 8'h07 : {s[6:0], 1'b0};
    end
    return s;
  endfunction
  always @(posedge tmo) begin
    n_errors++;
    give_verdict();
  end
  initial begin
    repeat (4) @(posedge ref_clk_i);
    chk({alert_n_o, wb_ack_o, latched_off_o}, 3'b100);
    reset_n_i <= 1'b1;
    host.xfer(1'b1, 6'h10, 32'h000A0B0C, q);
    for (int i = 0; i < 4; i++) begin
      r = rows[i];
      cmd({9'h000, r[47:40]});
      host.xfer(1'b0, 6'h08, 32'h0, q);
      chk(q, r[39:8]);
      f = r[47:40] == 8'hE1;
      p = crc8(r[47:40], {24'h0, r[7:0], r[39:8]}, f ? 5 : 4);
      host.xfer(1'b0, 6'h0C, 32'h0, q);
      chk({q[26:24], q[15:0]},
        f ? {3'd6, p, r[7:0]} : {3'd5, 8'h00, p});
    end
    cmd({1'b0, 8'h50, 8'hDF});
    chk(fan_duty_o, 8'h50);
    fan_internal_i <= 8'h30;
    cmd({1'b0, 8'h00, 8'hE0});
    chk(fan_duty_o, 8'h30);
    cmd({1'b0, 8'h10, 8'hDF});
    chk(fan_duty_o, 8'h30);
    cmd({1'b0, 8'h65, 8'hDF});
    chk({alert_n_o, fan_duty_o}, 9'h030);
    host.xfer(1'b1, 6'h04, 32'h0, q);
    cmd({1'b1, 8'h00, 8'hDA});
    cmd({1'b0, 8'h00, 8'h55});
    host.xfer(1'b0, 6'h04, 32'h0, q);
    chk({q[7], q[5], alert_n_o}, 3'b110);
    host.xfer(1'b1, 6'h04, 32'h0, q);
    cmd({1'b0, 8'h00, 8'hDA});
    iso_done_i <= 1'b1;
    cmd({1'b0, 8'h00, 8'hE2});
    host.xfer(1'b0, 6'h04, 32'h0, q);
    chk({q[3], alert_n_o}, 2'b11);
    for (int i = 0; i < 5; i++) begin
      ov_trip_i <= 1'b1;
      repeat (4) @(posedge ref_clk_i);
      ov_trip_i <= 1'b0;
      repeat (i == 1 ? 230 : 26) @(posedge ref_clk_i);
      if (i == 3) chk(latched_off_o, 1'b0);
    end
    chk(latched_off_o, 1'b1);
    enable_pin_i <= 1'b1;
    repeat (10) @(posedge ref_clk_i);
    enable_pin_i <= 1'b0;
    repeat (8) @(posedge ref_clk_i);
    host.xfer(1'b0, 6'h04, 32'h0, q);
    chk({latched_off_o, q[2], alert_n_o}, 3'b010);
    give_verdict();
  end
endmodule

// file: rmc_host_model.sv
`timescale 1ns/1ps
module rmc_host_model (
  input wire logic clk_i, ack_i,
  input wire logic [31:0] rdat_i,
  output logic cyc_o, stb_o, we_o, tmo_o,
  output logic [5:0] adr_o,
  output logic [3:0] sel_o,
  output logic [31:0] wdat_o
);
  initial {cyc_o, stb_o, we_o, tmo_o, adr_o, sel_o, wdat_o} = '0;
  task automatic xfer(input logic w, input logic [5:0] a,
      input logic [31:0] d, output logic [31:0] q);
    int n;
    @(posedge clk_i);
    {cyc_o, stb_o, we_o, adr_o, sel_o, wdat_o} <= {2'b11, w, a, 4'hF, d};
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_i !== 1'b1 && n < 50);
    q = rdat_i;
    if (n >= 50) tmo_o <= 1'b1;
    {cyc_o, stb_o, we_o} <= 3'b000;
  endtask
endmodule

// file: rmc_params.svh
// Notes on behaviour
// (RULE1) Host keeps unit off at least 2 s before re-enabling, except restart.
// (RULE2) Successful restart clears all alarms and sets restarted-ok status bit.
// (RULE3) Latch-off ends on enable, operation, reinsertion or ac toggle, or restart.
// (RULE4) Auto-restart command returns OV, OC, OT policy to automatic restart.
// (RULE5) After OV shutdown retry after 1 s; latch off on three within 1 min.
// (RULE6) Fewer than three OV shutdowns in window: clear count, new window.
// (RULE7) Isolation test command starts the OR-ing self-test.
// (RULE8) Host waits about 30 s, checks redundancy, tests one unit at a time.
// (RULE9) Isolation failure is information only, never an internal fault.
// (RULE10) Input read: count 4, voltage, power low, power high, error code.
// (RULE11) Input voltage byte is reported with 75 V subtracted.
// (RULE12) Revision read: primary, signal processor, interface, then error code.
// (RULE13) Revision zero means unsupported; high nibble major, low nibble minor.
// (RULE14) Run-timer read: count 4, three hour bytes low first, error code.
// (RULE15) Hours count in standby or main output, range about ten years.
// (RULE16) Fan-set carries one byte of duty in percent, 0x64 is full speed.
// (RULE17) Requested duty used only when above the internal demand.
// (RULE18) Fan-normal has no data and returns fan to internal control.
// (RULE19) Fan read: count 5, adjustment percent, three fan bytes, error code.
// (RULE20) Missing fan or unsupported fan read returns 0x00.
// (RULE21) Clock-hold test command holds serial clock low about 25 ms.
// (RULE22) Unsupported command or bad data sets status bits and raises alert.
// (RULE23) Status-2 bit 5 flags unsupported command, alerts, cleared by clear-flags.
// (RULE24) Status-2 bit 2 tells host a restart cleared status and alarms.
// (RULE25) Error code mismatch sets status-2 bit 7 and the command is dropped.
// (RULE26) Host block read: command, repeated start, ack data, nack error code.
`ifndef RMC_PARAMS_SVH
`define RMC_PARAMS_SVH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define RMC_OFS_CMD 6'h00
`define RMC_OFS_STATUS2 6'h04
`define RMC_OFS_RESP_LO 6'h08
`define RMC_OFS_RESP_HI 6'h0C
`define RMC_OFS_HOURS 6'h10
`define RMC_OFS_FAN 6'h14
`define RMC_OFS_STATE 6'h18

// ----------------------------------------
// Command codes and data values
// ----------------------------------------
`define RMC_CMD_OPERATION 8'h01
`define RMC_CMD_AUTO_RESTART 8'hD9
`define RMC_CMD_ISO_TEST 8'hDA
`define RMC_CMD_READ_INPUT 8'hDC
`define RMC_CMD_READ_REV 8'hDD
`define RMC_CMD_READ_TIMER 8'hDE
`define RMC_CMD_FAN_SET 8'hDF
`define RMC_CMD_FAN_NORMAL 8'hE0
`define RMC_CMD_READ_FAN 8'hE1
`define RMC_CMD_CLOCK_HOLD 8'hE2
`define RMC_OP_ON 8'h80
`define RMC_OP_OFF 8'h00
`define RMC_FAN_FULL 8'h64
`define RMC_VIN_OFFSET 9'h04B
`define RMC_CNT_INPUT 8'h04
`define RMC_CNT_REV 8'h03
`define RMC_CNT_TIMER 8'h04
`define RMC_CNT_FAN 8'h05
`define RMC_CRC_POLY 8'h07
`define RMC_OV_LIMIT 2'h3
`define RMC_SLAVE_ADDR 7'h58

// ----------------------------------------
// Status-2 bit positions
// ----------------------------------------
`define RMC_ST2_CRC_ERR 7
`define RMC_ST2_WILL_RESTART 6
`define RMC_ST2_INVALID 5
`define RMC_ST2_ISO_FAIL 3
`define RMC_ST2_RESTARTED 2
`define RMC_ST2_ENABLE_HI 0

// ----------------------------------------
// Timing
// ----------------------------------------
`define RMC_CLK_HZ 64'd50000000
`define RMC_RETRY_MS 64'd1000
`define RMC_WINDOW_MS 64'd60000
`define RMC_HOLD_MS 64'd25
`define RMC_HOUR_MS 64'd3600000
`define RMC_MS_CYC(ms) (((ms) * `RMC_CLK_HZ) / 64'd1000)
`define RMC_RETRY_CYC `RMC_MS_CYC(`RMC_RETRY_MS)
`define RMC_WINDOW_CYC `RMC_MS_CYC(`RMC_WINDOW_MS)
`define RMC_HOLD_CYC `RMC_MS_CYC(`RMC_HOLD_MS)
`define RMC_HOUR_CYC `RMC_MS_CYC(`RMC_HOUR_MS)

`endif

// file: rmc_pkg.sv
package rmc_pkg;
  typedef enum logic {
    RMC_IDLE,
    RMC_CRC
  } rmc_state_t;
endpackage
